// [hdl/gpc_cfg.svh]
// gpc_cfg.svh: offsets, field positions, reset values and timing counts of the game port
`ifndef GPC_CFG_SVH
`define GPC_CFG_SVH

// register indices; byte address on the bus is four times the index
`define GPC_IDX_CTL 4'h0
`define GPC_IDX_LST 4'h1
`define GPC_IDX_XST 4'h2
`define GPC_IDX_IEN 4'h3
`define GPC_IDX_AXL 4'h4
`define GPC_IDX_AXH 4'h5
`define GPC_IDX_AYL 4'h6
`define GPC_IDX_AYH 4'h7
`define GPC_IDX_BXL 4'h8
`define GPC_IDX_BXH 4'h9
`define GPC_IDX_BYL 4'ha
`define GPC_IDX_BYH 4'hb
`define GPC_IDX_POL 4'hc

// port_control fields
`define GPC_CTL_ENH 0
`define GPC_CTL_PRE_A 1
`define GPC_CTL_PRE_B 2
`define GPC_CTL_DEB_LSB 4
`define GPC_CTL_WMASK 8'hf7

// reset values
`define GPC_CTL_RST 8'h00
`define GPC_XST_RST 8'h00
`define GPC_IEN_RST 8'h00
`define GPC_POL_RST 8'h00

// interrupt_enables fields beyond the four button bits
`define GPC_IEN_POS_A 4
`define GPC_IEN_POS_B 5
`define GPC_IEN_WMASK 8'h3f

// timing
`define GPC_CLK_PERIOD_NS 8
`define GPC_DISCH_NS 1500
`define GPC_DISCH_CYC ((`GPC_DISCH_NS + `GPC_CLK_PERIOD_NS - 1) / `GPC_CLK_PERIOD_NS)
`define GPC_TICK_NS 1000
`define GPC_TICK_CYC (`GPC_TICK_NS / `GPC_CLK_PERIOD_NS)
`define GPC_DEB_MS 16
`define GPC_DEB_CYC (`GPC_DEB_MS * 1000000 / `GPC_CLK_PERIOD_NS)

`endif

// [hdl/gpc_pkg.sv]
// gpc_pkg.sv: types shared by the game port modules
package gpc_pkg;

  // per-axis line state: held low, released and charging, discharging
  typedef enum logic [2:0] {
    GPC_AX_IDLE = 3'b001,
    GPC_AX_CHARGE = 3'b010,
    GPC_AX_DISCH = 3'b100
  } gpc_axis_state_e;

endpackage : gpc_pkg

// [hdl/gpc_axis.sv]
// gpc_axis.sv: one axis line with its release, discharge and position counter
`timescale 1ns/1ps
`default_nettype none
`include "gpc_cfg.svh"

module gpc_axis #(
  parameter int unsigned DISCH_CYC = `GPC_DISCH_CYC,
  parameter int unsigned CNT_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic enh_i,
  input wire logic tick_i,
  input wire logic line_hi_i,
  output logic line_oe_o,
  output logic charging_o,
  output logic [CNT_W-1:0] count_o,
  output logic done_o
);
  import gpc_pkg::*;

  localparam int unsigned DW = $clog2(DISCH_CYC + 1);
  localparam logic [DW-1:0] DISCH_LAST = DW'(DISCH_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = {CNT_W{1'b1}};

  gpc_axis_state_e state_reg;
  logic [DW-1:0] disch_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic stop_reg;
  logic done_reg;

  wire charging = (state_reg == GPC_AX_CHARGE);
  wire sat_hit = charging && enh_i && tick_i && !stop_reg && (cnt_reg == CNT_FULL - 1'b1);
  wire hi_stop = charging && line_hi_i && !stop_reg && enh_i;

  // line state; a start in charge or discharge is simply not looked at
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= GPC_AX_IDLE;
      disch_reg <= '0;
    end else begin
      case (state_reg)
        GPC_AX_IDLE: begin
          if (start_i) begin
            state_reg <= GPC_AX_CHARGE;
          end
        end
        GPC_AX_CHARGE: begin
          if (line_hi_i) begin
            state_reg <= GPC_AX_DISCH;
            disch_reg <= '0;
          end
        end
        GPC_AX_DISCH: begin
          disch_reg <= disch_reg + 1'b1;
          if (disch_reg == DISCH_LAST) begin
            state_reg <= GPC_AX_IDLE;
          end
        end
        default: begin
          state_reg <= GPC_AX_IDLE;
        end
      endcase
    end
  end

  // position counter: cleared by start, counts ticks, saturates, then holds
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      stop_reg <= 1'b1;
    end else if (state_reg == GPC_AX_IDLE && start_i && enh_i) begin
      cnt_reg <= '0;
      stop_reg <= 1'b0;
    end else if (hi_stop) begin
      stop_reg <= 1'b1;
    end else if (charging && enh_i && tick_i && !stop_reg) begin
      cnt_reg <= cnt_reg + 1'b1;
      stop_reg <= sat_hit;
    end
  end

  // one pulse when counting stops, by the line or by saturation
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= hi_stop || sat_hit;
    end
  end

  assign line_oe_o = !charging;
  assign charging_o = charging;
  assign count_o = cnt_reg;
  assign done_o = done_reg;

endmodule : gpc_axis
`default_nettype wire

// [hdl/gpc_top.sv]
// gpc_top.sv: game port position capture with wishbone register slave
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "gpc_cfg.svh"

// Functional notes
// - a write to index one releases idle axis lines and starts reading.
// - on first high, drive the line low about 1.5 us, then hold low.
// - starts are ignored per line while charging or discharging.
// - legacy status shows raw button levels, no polarity applied.
// - control bit 0 clear, its reset value, means legacy mode.
// - in legacy mode a released axis reads one in legacy status.
// - legacy mode applies no debounce to any input.
// - control bit 0 set selects enhanced mode.
// - enhanced mode: four 16-bit counters count from release to axis high.
// - a counter that stops sets its ready flag in extended status.
// - a counter stops at full value if the axis never goes high.
// - counters tick at 1 MHz or 500 kHz, chosen per device.
// - enhanced mode offers a 16 ms button debouncer, off after reset.
// - legacy mode raises no interrupt request.
// - enhanced mode records button events in extended status.
// - button events are edges; the edge select register picks direction.
// - each button and device ready event has its own interrupt enable.
// - writing one clears a status bit; writing zero leaves it.
// - outside a reading the port drives all axis lines low.
// - the start write also clears the counters of idle lines in enhanced mode.
// - prescale bit zero gives 1 MHz, one gives 500 kHz.
// - each button has its own debounce enable bit.
module gpc_top #(
  parameter int unsigned DEB_CYC = `GPC_DEB_CYC,
  parameter int unsigned TICK_CYC = `GPC_TICK_CYC,
  parameter int unsigned DISCH_CYC = `GPC_DISCH_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // axis lines: 0 horizontal a, 1 vertical a, 2 horizontal b, 3 vertical b
  input wire logic [3:0] axis_line_i,
  output logic [3:0] axis_line_o,
  output logic [3:0] axis_line_oe_o,
  // button inputs: 0 a0, 1 a1, 2 b0, 3 b1
  input wire logic [3:0] button_inputs_i,
  output logic irq_o
);
  import gpc_pkg::*;

  localparam int unsigned DBW = $clog2(DEB_CYC + 1);
  localparam logic [DBW-1:0] DEB_LAST = DBW'(DEB_CYC - 1);
  localparam int unsigned TKW = $clog2(TICK_CYC + 1);
  localparam logic [TKW-1:0] TICK_LAST = TKW'(TICK_CYC - 1);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] port_control_reg;
  logic [7:0] extended_event_status_reg;
  logic [7:0] extended_event_status_next;
  logic [7:0] interrupt_enables_reg;
  logic [7:0] button_edge_select_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;

  // ---------------------------------------------------------------
  // pin synchronisers, two flops each, nothing reads the first
  // ---------------------------------------------------------------
  logic [3:0] axis_s1_reg;
  logic [3:0] axis_s2_reg;
  logic [3:0] btn_s1_reg;
  logic [3:0] btn_s2_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      axis_s1_reg <= 4'h0;
      axis_s2_reg <= 4'h0;
      btn_s1_reg <= 4'h0;
      btn_s2_reg <= 4'h0;
    end else begin
      axis_s1_reg <= axis_line_i;
      axis_s2_reg <= axis_s1_reg;
      btn_s1_reg <= button_inputs_i;
      btn_s2_reg <= btn_s1_reg;
    end
  end

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire [3:0] reg_idx = wb_adr_i[5:2];
  wire bus_req = wb_cyc_i && wb_stb_i;
  wire wr_commit = bus_req && wb_we_i && ack_reg && wb_sel_i[0];
  wire wr_ctl = wr_commit && (reg_idx == `GPC_IDX_CTL);
  wire wr_start = wr_commit && (reg_idx == `GPC_IDX_LST);
  wire wr_xst = wr_commit && (reg_idx == `GPC_IDX_XST);
  wire wr_ien = wr_commit && (reg_idx == `GPC_IDX_IEN);
  wire wr_pol = wr_commit && (reg_idx == `GPC_IDX_POL);

  wire enh = port_control_reg[`GPC_CTL_ENH];
  wire pre_a = port_control_reg[`GPC_CTL_PRE_A];
  wire pre_b = port_control_reg[`GPC_CTL_PRE_B];
  wire [3:0] deb_en = port_control_reg[`GPC_CTL_DEB_LSB +: 4];

  // ---------------------------------------------------------------
  // counter clock enables from the system clock
  // ---------------------------------------------------------------
  logic [TKW-1:0] tick_div_reg;
  logic half_reg;
  wire tick_fast = (tick_div_reg == TICK_LAST);
  wire tick_slow = tick_fast && half_reg;

  // 1 MHz strobe and every second one of them for 500 kHz
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_div_reg <= '0;
      half_reg <= 1'b0;
    end else if (tick_fast) begin
      tick_div_reg <= '0;
      half_reg <= !half_reg;
    end else begin
      tick_div_reg <= tick_div_reg + 1'b1;
    end
  end

  // per device rate select
  wire tick_a = pre_a ? tick_slow : tick_fast;
  wire tick_b = pre_b ? tick_slow : tick_fast;
  wire [3:0] axis_tick = {tick_b, tick_b, tick_a, tick_a};

  // ---------------------------------------------------------------
  // four axis lines
  // ---------------------------------------------------------------
  logic [3:0] axis_oe;
  logic [3:0] axis_charging;
  logic [3:0] axis_done;
  logic [15:0] axis_count [4];

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_axis
      gpc_axis #(
        .DISCH_CYC(DISCH_CYC),
        .CNT_W(16)
      ) u_axis (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(wr_start),
        .enh_i(enh),
        .tick_i(axis_tick[g]),
        .line_hi_i(axis_s2_reg[g]),
        .line_oe_o(axis_oe[g]),
        .charging_o(axis_charging[g]),
        .count_o(axis_count[g]),
        .done_o(axis_done[g])
      );
    end
  endgenerate

  // lines only ever pull low; the external rc network charges them
  assign axis_line_o = 4'h0;
  assign axis_line_oe_o = axis_oe;

  // ---------------------------------------------------------------
  // button debounce, only in effect in enhanced mode
  // ---------------------------------------------------------------
  logic [3:0] deb_reg;
  logic [DBW-1:0] deb_cnt_reg [4];
  logic [3:0] btn_prev_reg;
  logic [3:0] btn_filt;

  generate
    for (g = 0; g < 4; g++) begin : g_deb
      // filter follows the pin while disabled, so enabling it is glitch free
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          deb_reg[g] <= 1'b0;
          deb_cnt_reg[g] <= '0;
        end else if (!(enh && deb_en[g]) || deb_reg[g] == btn_s2_reg[g]) begin
          deb_reg[g] <= btn_s2_reg[g];
          deb_cnt_reg[g] <= '0;
        end else if (deb_cnt_reg[g] == DEB_LAST) begin
          deb_reg[g] <= btn_s2_reg[g];
          deb_cnt_reg[g] <= '0;
        end else begin
          deb_cnt_reg[g] <= deb_cnt_reg[g] + 1'b1;
        end
      end

      // legacy mode always sees the unfiltered level
      assign btn_filt[g] = (enh && deb_en[g]) ? deb_reg[g] : btn_s2_reg[g];
    end
  endgenerate

  // previous filtered level for edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      btn_prev_reg <= 4'h0;
    end else begin
      btn_prev_reg <= btn_filt;
    end
  end

  // edge select bit one means rising edge, zero means falling edge
  wire [3:0] btn_rise = btn_filt & ~btn_prev_reg;
  wire [3:0] btn_fall = ~btn_filt & btn_prev_reg;
  wire [3:0] btn_sel = button_edge_select_reg[3:0];
  wire [3:0] btn_event = (btn_sel & btn_rise) | (~btn_sel & btn_fall);

  // ---------------------------------------------------------------
  // extended status: events low nibble, axis ready high nibble
  // ---------------------------------------------------------------
  wire [7:0] xst_set = enh ? {axis_done, btn_event} : 8'h00;
  wire [7:0] xst_clr = wr_xst ? wb_dat_i[7:0] : 8'h00;

  // a set in the same cycle as its clear wins
  assign extended_event_status_next = xst_set | (extended_event_status_reg & ~xst_clr);

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_control_reg <= `GPC_CTL_RST;
      extended_event_status_reg <= `GPC_XST_RST;
      interrupt_enables_reg <= `GPC_IEN_RST;
      button_edge_select_reg <= `GPC_POL_RST;
    end else begin
      extended_event_status_reg <= extended_event_status_next;
      if (wr_ctl) begin
        port_control_reg <= wb_dat_i[7:0] & `GPC_CTL_WMASK;
      end
      if (wr_ien) begin
        interrupt_enables_reg <= wb_dat_i[7:0] & `GPC_IEN_WMASK;
      end
      if (wr_pol) begin
        button_edge_select_reg <= {4'h0, wb_dat_i[3:0]};
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt request; a device is ready when both its axes are
  // ---------------------------------------------------------------
  wire [3:0] rdy = extended_event_status_reg[7:4];
  wire pos_a = rdy[0] && rdy[1];
  wire pos_b = rdy[2] && rdy[3];
  wire [5:0] irq_src = {pos_b, pos_a, extended_event_status_reg[3:0]};
  wire irq_any = |(irq_src & interrupt_enables_reg[5:0]);
  logic irq_reg;

  // registered so the pin never glitches while status settles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= enh && irq_any;
    end
  end

  assign irq_o = irq_reg;

  // ---------------------------------------------------------------
  // read selection
  // ---------------------------------------------------------------
  // legacy status: raw buttons high nibble, released axes low nibble
  wire [7:0] legacy_pin_status = {btn_s2_reg, axis_charging};
  wire [15:0] cnt_ax = axis_count[0];
  wire [15:0] cnt_ay = axis_count[1];
  wire [15:0] cnt_bx = axis_count[2];
  wire [15:0] cnt_by = axis_count[3];

  wire [7:0] rd_mux =
    (reg_idx == `GPC_IDX_CTL) ? port_control_reg :
    (reg_idx == `GPC_IDX_LST) ? legacy_pin_status :
    (reg_idx == `GPC_IDX_XST) ? extended_event_status_reg :
    (reg_idx == `GPC_IDX_IEN) ? interrupt_enables_reg :
    (reg_idx == `GPC_IDX_AXL) ? cnt_ax[7:0] :
    (reg_idx == `GPC_IDX_AXH) ? cnt_ax[15:8] :
    (reg_idx == `GPC_IDX_AYL) ? cnt_ay[7:0] :
    (reg_idx == `GPC_IDX_AYH) ? cnt_ay[15:8] :
    (reg_idx == `GPC_IDX_BXL) ? cnt_bx[7:0] :
    (reg_idx == `GPC_IDX_BXH) ? cnt_bx[15:8] :
    (reg_idx == `GPC_IDX_BYL) ? cnt_by[7:0] :
    (reg_idx == `GPC_IDX_BYH) ? cnt_by[15:8] :
    (reg_idx == `GPC_IDX_POL) ? button_edge_select_reg :
    8'h00;

  // ---------------------------------------------------------------
  // bus answer: ack one cycle after the request, dropped the next
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0;
    end else begin
      ack_reg <= bus_req && !ack_reg;
      if (bus_req && !ack_reg) begin
        rdata_reg <= {24'h0, rd_mux};
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

endmodule : gpc_top
`default_nettype wire

// [verif/gpc_rc_model.sv]
// gpc_rc_model.sv: behavioural rc charging networks hanging on the four axis lines
`timescale 1ns/1ps
`default_nettype none
module gpc_rc_model (
  input wire logic clk_i,
  input wire logic [3:0] oe_i,
  input wire logic [3:0][19:0] dly_i,
  output logic [3:0] line_o
);
  logic [19:0] age_reg [4];
  // time since release; a line the port pulls low restarts its capacitor from empty
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 4; i++) begin
      age_reg[i] <= oe_i[i] ? 20'h0 : age_reg[i] + 20'h1;
    end
  end
  // wired level: low while the port drives it; a zero delay models a stick that never charges
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      line_o[i] = !oe_i[i] && (dly_i[i] != 20'h0) && (age_reg[i] >= dly_i[i]);
    end
  end
endmodule : gpc_rc_model
`default_nettype wire

// [verif/gpc_top_checker.sv]
// gpc_top_checker.sv: port assertions for the game port block
`timescale 1ns/1ps
`default_nettype none
module gpc_top_checker #(
  parameter int unsigned DEB_CYC = 20,
  parameter int unsigned TICK_CYC = 4,
  parameter int unsigned DISCH_CYC = 188
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [3:0] axis_line_i,
  input wire logic [3:0] axis_line_o,
  input wire logic [3:0] axis_line_oe_o,
  input wire logic [3:0] button_inputs_i,
  input wire logic irq_o
);
  logic enh_reg;
  logic [5:0] ien_reg;
  logic [8:0] hi_reg;
  // writes commit on the acknowledged edge, so the shadows follow the same edge
  wire logic wr_ack = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & wb_ack_o;
  wire logic start_ack = wr_ack & (wb_adr_i[5:2] == 4'h1);
  wire logic enh_next = (wr_ack && wb_adr_i[5:2] == 4'h0) ? wb_dat_i[0] : enh_reg;
  wire logic [5:0] ien_next = (wr_ack && wb_adr_i[5:2] == 4'h3) ? wb_dat_i[5:0] : ien_reg;
  // cycles line 0 has been pulled low; saturates so a long idle stays recognisable
  wire logic [8:0] hi_next = !axis_line_oe_o[0] ? 9'h0 : hi_reg + {8'h0, hi_reg != 9'h1ff};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enh_reg <= 1'b0;
      ien_reg <= 6'h0;
      hi_reg <= 9'h1ff;
    end else begin
      enh_reg <= enh_next;
      ien_reg <= ien_next;
      hi_reg <= hi_next;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus request not answered by one ack pulse");
  start_release_a: assert property (start_ack && hi_reg > DISCH_CYC + 1 |=> !axis_line_oe_o[0])
    else $error("idle axis line not released by start");
  refuse_start_a: assert property ((|($past(axis_line_oe_o) & ~axis_line_oe_o)) |-> $past(start_ack))
    else $error("axis line released without a start write");
  disch_hold_a: assert property ($fell(axis_line_oe_o[0]) |-> $past(hi_reg) >= DISCH_CYC)
    else $error("axis line released during its discharge interval");
  sense_drive_a: assert property ($rose(axis_line_i[1]) && !axis_line_oe_o[1] |-> ##[1:4] axis_line_oe_o[1])
    else $error("charged axis line not driven low");
  reset_hold_a: assert property (disable iff (1'b0) rst_i |=> axis_line_oe_o == 4'hf && !irq_o && !wb_ack_o)
    else $error("reset state wrong on axis lines or outputs");
  pin_low_a: assert property (axis_line_o == 4'h0)
    else $error("axis line driven to a high level");
  legacy_quiet_a: assert property (!enh_reg && !$past(enh_reg) |-> !irq_o)
    else $error("interrupt raised in legacy mode");
  irq_gate_a: assert property (ien_reg == 6'h0 && $past(ien_reg) == 6'h0 |-> !irq_o)
    else $error("interrupt raised with all sources disabled");
endmodule : gpc_top_checker
bind gpc_top gpc_top_checker #(.DEB_CYC(DEB_CYC), .TICK_CYC(TICK_CYC), .DISCH_CYC(DISCH_CYC)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .axis_line_i(axis_line_i), .axis_line_o(axis_line_o),
  .axis_line_oe_o(axis_line_oe_o), .button_inputs_i(button_inputs_i), .irq_o(irq_o));
`default_nettype wire

// [verif/gpc_top_tb_top.sv]
// gpc_top_tb_top.sv: self-checking bench for the game port capture block
`timescale 1ns/1ps
`default_nettype none
module gpc_top_tb_top;
  localparam int TICK = 1;
  localparam logic [3:0] RIDX [5] = '{4'h0, 4'h2, 4'h3, 4'hc, 4'hd};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [5:0] wb_adr_i = 6'h00;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, irq_o, exp1;
  logic [3:0] line_w, line_o, oe, sel_v;
  logic [3:0] btn = 4'h0;
  logic [3:0][19:0] dly = '0;
  logic [7:0] v, lo, pol;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  int n, k, per;
  gpc_top #(.DEB_CYC(20), .TICK_CYC(unsigned'(TICK)), .DISCH_CYC(188)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .axis_line_i(line_w), .axis_line_o(line_o), .axis_line_oe_o(oe),
    .button_inputs_i(btn), .irq_o(irq_o));
  gpc_rc_model rc (.clk_i(clk_i), .oe_i(oe), .dly_i(dly), .line_o(line_w));
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  // hang guard: the saturation wait alone needs about 66k cycles at one tick per cycle
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 90000) begin
      err_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [15:0] got, input logic [15:0] want, input string what);
    checks++;
    if (got !== want) begin
      err_count++;
      $display("ERROR at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask : chk
  // count tolerance covers tick phase and the two-flop input sync
  task automatic near(input logic [15:0] got, input int d, input int p);
    checks++;
    if ($isunknown(got) || got + 2 < (d + 3) / p || got > (d + 3) / p + 2) begin
      err_count++;
      $display("ERROR at %0t: count %h for delay %0d", $time, got, d);
    end
  endtask : near
  // one classic cycle, held until ack is sampled high; only the hang guard ends the wait
  task automatic bus(input logic we, input logic [3:0] idx, input logic [7:0] wd);
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= sel_v;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h0, wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    // ack stands in the cycle after the request is taken
    chk(16'(n), 16'h2, "ack latency");
    v = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task automatic rdc(input logic [3:0] idx, input logic [7:0] m, input logic [7:0] e, string w);
    bus(1'b0, idx, 8'h00);
    chk({8'h0, v & m}, {8'h0, e}, w);
  endtask : rdc
  initial begin
    sel_v = 4'h1;
    void'($urandom(79550));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (RIDX[i]) begin
      rdc(RIDX[i], 8'hff, 8'h00, "reset value");
    end
    // reserved bit stays zero; a write without lane 0 is dropped
    bus(1'b1, 4'h0, 8'hfe);
    sel_v = 4'he;
    bus(1'b1, 4'h0, 8'h00);
    sel_v = 4'h1;
    rdc(4'h0, 8'hff, 8'hf6, "control");
    // legacy: debounce bits set, yet buttons must show raw within a few cycles
    for (int i = 0; i < 4; i++) begin
      dly[i] <= 20'd40 + 20'($urandom % 260);
    end
    btn <= 4'($urandom);
    bus(1'b1, 4'h1, 8'h5a);
    repeat (4) @(posedge clk_i);
    rdc(4'h1, 8'hff, {btn, 4'hf}, "legacy status");
    bus(1'b1, 4'h1, 8'h00);
    repeat (320) @(posedge clk_i);
    rdc(4'h1, 8'h0f, 8'h00, "legacy axes");
    // enhanced: device a at 500 kHz then 1 MHz; the last line never charges
    dly[3] <= 20'h0;
    for (int r = 0; r < 2; r++) begin
      per = TICK * (r == 0 ? 2 : 1);
      bus(1'b1, 4'h0, {6'h0, r == 0, 1'b1});
      for (int i = 0; i < 3; i++) begin
        dly[i] <= 20'd40 + 20'($urandom % 360);
      end
      bus(1'b1, 4'h1, 8'hff);
      k = 0;
      do begin
        bus(1'b0, 4'h2, 8'h00);
        k++;
      end while ((v & 8'h70) != 8'h70 && k < 1000);
      chk({13'h0, v[6:4]}, 16'h7, "ready flags");
      for (int i = 0; i < 3; i++) begin
        bus(1'b0, 4'(4 + 2 * i), 8'h00);
        lo = v;
        bus(1'b0, 4'(5 + 2 * i), 8'h00);
        near({v, lo}, int'(dly[i]), i < 2 ? per : TICK);
      end
      repeat (50) @(posedge clk_i);
      rdc(4'h8, 8'hff, lo, "held count");
      bus(1'b1, 4'h3, 8'h10);
      repeat (3) @(posedge clk_i);
      chk({15'h0, irq_o}, 16'h1, "position irq");
      bus(1'b1, 4'h3, 8'h00);
      bus(1'b1, 4'h2, 8'h00);
      rdc(4'h2, 8'h70, 8'h70, "write zero keeps");
      bus(1'b1, 4'h2, 8'hff);
      rdc(4'h2, 8'h70, 8'h00, "write one clears");
      repeat (200) @(posedge clk_i);
    end
    // each button toggled both ways under a random edge select, enabled alone
    pol = 8'($urandom % 16);
    bus(1'b1, 4'hc, pol);
    rdc(4'hc, 8'hff, pol, "edge select");
    bus(1'b1, 4'h2, 8'h0f);
    for (int b = 0; b < 4; b++) begin
      bus(1'b1, 4'h3, 8'(1 << b));
      for (int e = 0; e < 2; e++) begin
        btn[b] <= ~btn[b];
        repeat (6) @(posedge clk_i);
        exp1 = (btn[b] == pol[b]);
        rdc(4'h2, 8'(1 << b), exp1 ? 8'(1 << b) : 8'h00, "button event");
        chk({15'h0, irq_o}, {15'h0, exp1}, "button irq");
        bus(1'b1, 4'h2, 8'h0f);
        rdc(4'h2, 8'h0f, 8'h00, "event clear");
      end
    end
    // debounce on button a0: a short glitch is swallowed, a steady level counts
    bus(1'b1, 4'h0, 8'h11);
    btn[0] <= ~pol[0];
    repeat (40) @(posedge clk_i);
    bus(1'b1, 4'h2, 8'h0f);
    btn[0] <= pol[0];
    repeat (5) @(posedge clk_i);
    btn[0] <= ~pol[0];
    repeat (40) @(posedge clk_i);
    rdc(4'h2, 8'h01, 8'h00, "glitch");
    btn[0] <= pol[0];
    repeat (40) @(posedge clk_i);
    rdc(4'h2, 8'h01, 8'h01, "debounced");
    // last line never charged: its counter must stop at full scale
    k = 0;
    do begin
      repeat (100) @(posedge clk_i);
      bus(1'b0, 4'h2, 8'h00);
      k++;
    end while (v[7] !== 1'b1 && k < 700);
    rdc(4'ha, 8'hff, 8'hff, "full low");
    rdc(4'hb, 8'hff, 8'hff, "full high");
    print_verdict();
  end
endmodule : gpc_top_tb_top
`default_nettype wire
